// ===== core/timer8_pkg.sv
// ----------------------------------------------------------------------------
// Operation
// - Mode field: 0 normal, 1/5 phase PWM, 2 clear-on-match, 3/7 fast PWM
// - Compare update timing and overflow flag point depend on mode
// - Fast PWM raises overflow flag on every arrival at TOP
// - Normal mode only increments, wraps 0xff to 0x00, never match-cleared
// - Normal mode overflow flag sets when counter becomes zero; counting never clears it
// - Overflow flag clears when its interrupt is serviced
// - Normal mode accepts counter writes at any time
// - Clear-on-match mode clears counter when it equals compare A
// - No double buffering there: compare below count means wrap before next match
// - Clear-on-match sets compare A flag at TOP; flag requests interrupt if enabled
// - Clear-on-match with output mode 1 toggles output A on every match
// - Output A reaches pin only while pin direction is output
// - Toggle frequency is clock over 2*N*(1+compare A)
// - Clear-on-match sets overflow flag when counter goes from MAX to zero
// - Fast PWM output mode 2 non-inverted, 3 inverted
// - Fast PWM drives one level at match, opposite at TOP-to-BOTTOM roll
// - Non-PWM modes: output mode bits set, clear or toggle on match
// - Clock select zero stops the counter; software access still works
// - Software counter write beats any clear or count in same cycle
// ----------------------------------------------------------------------------
package timer8_pkg;

    // ------------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------------
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_COUNTER = 3'h1;
    localparam logic [2:0] ADDR_COMPARE = 3'h2;
    localparam logic [2:0] ADDR_FLAGS   = 3'h3;
    localparam logic [2:0] ADDR_ENABLE  = 3'h4;

    // ------------------------------------------------------------------------
    // Control field and flag bit positions
    // ------------------------------------------------------------------------
    localparam int MODE_LSB  = 0;
    localparam int CS_LSB    = 3;
    localparam int COM_LSB   = 6;
    localparam int DIR_BIT   = 8;
    localparam int FLAG_OVF  = 0;
    localparam int FLAG_CMPA = 1;

    // ------------------------------------------------------------------------
    // Values and reset values
    // ------------------------------------------------------------------------
    localparam logic [7:0] COUNT_MAX    = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_RST    = 8'h00;
    localparam logic [7:0] COMPARE_RST  = 8'h00;
    localparam logic [2:0] CS_STOPPED   = 3'h0;
    localparam logic [10:0] PRESCALE_MAX = 11'h400;

    localparam logic [2:0] MODE_NORMAL  = 3'h0;
    localparam logic [2:0] MODE_PC_FF   = 3'h1;
    localparam logic [2:0] MODE_CTC     = 3'h2;
    localparam logic [2:0] MODE_FAST_FF = 3'h3;
    localparam logic [2:0] MODE_PC_CMP  = 3'h5;
    localparam logic [2:0] MODE_FAST_CM = 3'h7;

    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    typedef struct packed {
        logic       dir_out;
        logic [1:0] compare_a_output_mode;
        logic [2:0] clock_select;
        logic [2:0] waveform_mode_sel;
    } control_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

endpackage : timer8_pkg

// ===== core/timer8_prescaler.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Timer clock enable from clock select: N = 1, 8, 32, 64, 128, 256, 1024
// ----------------------------------------------------------------------------
module timer8_prescaler (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Selection and enable
    input  wire logic [2:0] clock_select,
    output logic            tick
);
    logic [9:0] div_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n || clock_select == timer8_pkg::CS_STOPPED) begin
            div_reg <= 10'h000;
        end else begin
            div_reg <= div_reg + 10'h001;
        end
    end

    always_comb begin
        case (clock_select)
            3'h1:    tick = 1'b1;
            3'h2:    tick = (div_reg[2:0] == 3'h7);
            3'h3:    tick = (div_reg[4:0] == 5'h1f);
            3'h4:    tick = (div_reg[5:0] == 6'h3f);
            3'h5:    tick = (div_reg[6:0] == 7'h7f);
            3'h6:    tick = (div_reg[7:0] == 8'hff);
            3'h7:    tick = (div_reg == 10'h3ff);
            default: tick = 1'b0;
        endcase
    end

endmodule : timer8_prescaler

// ===== core/timer8_waveform_modes.sv
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module timer8_waveform_modes (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Interrupt service acknowledges
    input  wire logic       ovf_serviced,
    input  wire logic       cmpa_serviced,
    // Interrupt requests
    output logic            ovf_irq,
    output logic            cmpa_irq,
    // Output pin
    output logic            compare_a_output,
    output logic            compare_a_output_oe
);
    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        KIND_NORMAL = 4'b0001,
        KIND_CTC    = 4'b0010,
        KIND_FAST   = 4'b0100,
        KIND_PHASE  = 4'b1000
    } kind_t;

    timer8_pkg::control_t control_reg;
    logic [7:0]  counter_value_reg;
    logic [7:0]  compare_a_value_reg;
    logic [7:0]  compare_buf_reg;
    logic        overflow_flag_reg;
    logic        compare_a_flag_reg;
    logic [1:0]  irq_en_reg;
    logic        out_reg;
    logic        down_reg;
    logic [7:0]  rdata_reg;
    kind_t       kind;
    logic [7:0]  top_value;
    logic        tick;
    logic        cnt_wr;
    logic        at_top;
    logic        match;
    logic        ovf_event;
    logic        cmp_load;
    logic [7:0]  counter_next;
    logic        down_next;

    always_comb begin
        case (control_reg.waveform_mode_sel)
            timer8_pkg::MODE_PC_FF,
            timer8_pkg::MODE_PC_CMP:  kind = KIND_PHASE;
            timer8_pkg::MODE_CTC:     kind = KIND_CTC;
            timer8_pkg::MODE_FAST_FF,
            timer8_pkg::MODE_FAST_CM: kind = KIND_FAST;
            default:                  kind = KIND_NORMAL;
        endcase
    end

    // TOP from compare A in modes 2, 5, 7
    assign top_value = (control_reg.waveform_mode_sel == timer8_pkg::MODE_CTC ||
                        control_reg.waveform_mode_sel == timer8_pkg::MODE_PC_CMP ||
                        control_reg.waveform_mode_sel == timer8_pkg::MODE_FAST_CM)
                       ? compare_a_value_reg : timer8_pkg::COUNT_MAX;

    timer8_prescaler u_prescaler (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .clock_select (control_reg.clock_select),
        .tick         (tick)
    );

    assign cnt_wr = wr && (addr == timer8_pkg::ADDR_COUNTER);
    assign at_top = (counter_value_reg == top_value);
    assign match  = (counter_value_reg == compare_a_value_reg);

    // ------------------------------------------------------------------------
    // Counter sequence
    // ------------------------------------------------------------------------
    always_comb begin
        counter_next = counter_value_reg;
        down_next    = down_reg;
        ovf_event    = 1'b0;
        cmp_load     = 1'b0;
        case (kind)
            KIND_CTC: begin
                if (at_top) begin
                    counter_next = timer8_pkg::COUNT_BOTTOM;
                end else begin
                    counter_next = counter_value_reg + 8'h01;
                end
                ovf_event = (counter_value_reg == timer8_pkg::COUNT_MAX);
            end
            KIND_FAST: begin
                if (at_top) begin
                    counter_next = timer8_pkg::COUNT_BOTTOM;
                    ovf_event    = 1'b1;
                end else begin
                    counter_next = counter_value_reg + 8'h01;
                end
                if (control_reg.waveform_mode_sel == timer8_pkg::MODE_FAST_CM) begin
                    cmp_load = (counter_next == timer8_pkg::COUNT_BOTTOM);
                end else begin
                    cmp_load = at_top;
                end
            end
            KIND_PHASE: begin
                if (!down_reg && at_top) begin
                    down_next = 1'b1;
                    cmp_load  = 1'b1;
                end else if (down_reg && counter_value_reg == timer8_pkg::COUNT_BOTTOM) begin
                    down_next = 1'b0;
                    ovf_event = 1'b1;
                end
                if (down_next) begin
                    counter_next = counter_value_reg - 8'h01;
                end else begin
                    counter_next = counter_value_reg + 8'h01;
                end
            end
            default: begin
                counter_next = counter_value_reg + 8'h01;
                ovf_event    = (counter_value_reg == timer8_pkg::COUNT_MAX);
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            counter_value_reg <= timer8_pkg::COUNT_RST;
            down_reg          <= 1'b0;
        end else if (cnt_wr) begin
            counter_value_reg <= wdata;
        end else if (tick) begin
            counter_value_reg <= counter_next;
            down_reg          <= down_next;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            control_reg <= '0;
            irq_en_reg  <= 2'h0;
        end else if (wr && addr == timer8_pkg::ADDR_CONTROL) begin
            control_reg <= {control_reg.dir_out, wdata};
        end else if (wr && addr == timer8_pkg::ADDR_ENABLE) begin
            irq_en_reg          <= wdata[1:0];
            // Pin direction is written through the enable byte but kept with the control bits
            control_reg.dir_out <= wdata[7];
        end
    end

    // Buffered in PWM modes; direct write in normal and clear-on-match
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            compare_buf_reg     <= timer8_pkg::COMPARE_RST;
            compare_a_value_reg <= timer8_pkg::COMPARE_RST;
        end else begin
            if (wr && addr == timer8_pkg::ADDR_COMPARE) begin
                compare_buf_reg <= wdata;
            end
            if (wr && addr == timer8_pkg::ADDR_COMPARE &&
                (kind == KIND_NORMAL || kind == KIND_CTC)) begin
                compare_a_value_reg <= wdata;
            end else if (tick && cmp_load) begin
                compare_a_value_reg <= compare_buf_reg;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Flags: hardware set wins over a clear in the same cycle
    // ------------------------------------------------------------------------
    logic flag_wr;
    assign flag_wr = wr && (addr == timer8_pkg::ADDR_FLAGS);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            overflow_flag_reg <= 1'b0;
        end else if (tick && ovf_event && !cnt_wr) begin
            overflow_flag_reg <= 1'b1;
        end else if (ovf_serviced || (flag_wr && wdata[timer8_pkg::FLAG_OVF])) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            compare_a_flag_reg <= 1'b0;
        end else if (tick && match && !cnt_wr) begin
            compare_a_flag_reg <= 1'b1;
        end else if (cmpa_serviced || (flag_wr && wdata[timer8_pkg::FLAG_CMPA])) begin
            compare_a_flag_reg <= 1'b0;
        end
    end

    assign ovf_irq  = overflow_flag_reg && irq_en_reg[timer8_pkg::FLAG_OVF];
    assign cmpa_irq = compare_a_flag_reg && irq_en_reg[timer8_pkg::FLAG_CMPA];

    // ------------------------------------------------------------------------
    // Waveform output
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_reg <= 1'b0;
        end else if (tick && !cnt_wr) begin
            case (kind)
                KIND_FAST: begin
                    if (control_reg.compare_a_output_mode[1]) begin
                        if (at_top) begin
                            out_reg <= ~control_reg.compare_a_output_mode[0];
                        end else if (match) begin
                            out_reg <= control_reg.compare_a_output_mode[0];
                        end
                    end else if (control_reg.compare_a_output_mode == timer8_pkg::COM_TOGGLE
                                 && match && control_reg.waveform_mode_sel[2]) begin
                        out_reg <= ~out_reg;
                    end
                end
                KIND_PHASE: begin
                    if (control_reg.compare_a_output_mode[1] && match) begin
                        out_reg <= control_reg.compare_a_output_mode[0] ^ down_reg;
                    end
                end
                default: begin
                    if (match) begin
                        case (control_reg.compare_a_output_mode)
                            timer8_pkg::COM_TOGGLE: out_reg <= ~out_reg;
                            timer8_pkg::COM_CLEAR:  out_reg <= 1'b0;
                            timer8_pkg::COM_SET:    out_reg <= 1'b1;
                            default:                out_reg <= out_reg;
                        endcase
                    end
                end
            endcase
        end
    end

    assign compare_a_output    = out_reg;
    assign compare_a_output_oe = control_reg.dir_out &&
                                 (control_reg.compare_a_output_mode != timer8_pkg::COM_OFF);

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (rd) begin
            case (addr)
                timer8_pkg::ADDR_CONTROL: rdata_reg <= control_reg[7:0];
                timer8_pkg::ADDR_COUNTER: rdata_reg <= counter_value_reg;
                timer8_pkg::ADDR_COMPARE: rdata_reg <= compare_buf_reg;
                timer8_pkg::ADDR_FLAGS:   rdata_reg <= {6'h00, compare_a_flag_reg,
                                                        overflow_flag_reg};
                timer8_pkg::ADDR_ENABLE:  rdata_reg <= {control_reg.dir_out, 5'h00, irq_en_reg};
                default:                  rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign rdata = rdata_reg;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_normal_wrap;
        @(posedge core_clk) disable iff (!rst_n)
        (kind == KIND_NORMAL && tick && !cnt_wr && counter_value_reg == 8'hff)
        |=> (counter_value_reg == 8'h00 && overflow_flag_reg);
    endproperty
    a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

    property p_ctc_clear;
        @(posedge core_clk) disable iff (!rst_n)
        (kind == KIND_CTC && tick && !cnt_wr && match) |=> (counter_value_reg == 8'h00);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("ctc not cleared");

    property p_wr_prio;
        @(posedge core_clk) disable iff (!rst_n)
        cnt_wr |=> (counter_value_reg == $past(wdata));
    endproperty
    a_wr_prio: assert property (p_wr_prio) else $error("write lost");

    property p_stopped;
        @(posedge core_clk) disable iff (!rst_n)
        (control_reg.clock_select == 3'h0 && !cnt_wr) |=> $stable(counter_value_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved");

    property p_ovf_sticky;
        @(posedge core_clk) disable iff (!rst_n)
        (overflow_flag_reg && !ovf_serviced && !flag_wr) |=> overflow_flag_reg;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("flag lost");

    property p_ctc_toggle;
        @(posedge core_clk) disable iff (!rst_n)
        (kind == KIND_CTC && tick && !cnt_wr && match &&
         control_reg.compare_a_output_mode == 2'h1) |=> (out_reg != $past(out_reg));
    endproperty
    a_ctc_toggle: assert property (p_ctc_toggle) else $error("no toggle");

    property p_fast_top;
        @(posedge core_clk) disable iff (!rst_n)
        (kind == KIND_FAST && tick && !cnt_wr && at_top) |=>
        (overflow_flag_reg && counter_value_reg == 8'h00);
    endproperty
    a_fast_top: assert property (p_fast_top) else $error("fast top wrong");

    property p_pin;
        @(posedge core_clk) disable iff (!rst_n)
        !control_reg.dir_out |-> !compare_a_output_oe;
    endproperty
    a_pin: assert property (p_pin) else $error("pin driven");

    // PWM modes may move compare A only at their update point
    property p_cmp_buffered;
        @(posedge core_clk) disable iff (!rst_n)
        ((kind == KIND_FAST || kind == KIND_PHASE) && !(tick && cmp_load))
        |=> $stable(compare_a_value_reg);
    endproperty
    a_cmp_buffered: assert property (p_cmp_buffered) else $error("compare early");

    c_ctc_wrap: cover property (@(posedge core_clk) kind == KIND_CTC && at_top && tick);
    c_fast_inv: cover property (@(posedge core_clk) kind == KIND_FAST &&
                                control_reg.compare_a_output_mode == 2'h3 && match);
    c_phase_bot: cover property (@(posedge core_clk) kind == KIND_PHASE && ovf_event && tick);

endmodule : timer8_waveform_modes

// ===== dv/test_timer8_waveform_modes.sv
`timescale 1ns/100ps
module test_timer8_waveform_modes;
    // ------------------------------------------------------------------------
    // Ports and bookkeeping
    // ------------------------------------------------------------------------
    logic       core_clk;
    logic       rst_n;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       ovf_serviced;
    logic       cmpa_serviced;
    logic       ovf_irq;
    logic       cmpa_irq;
    logic       compare_a_output;
    logic       compare_a_output_oe;
    int         n_errors;
    int         n_compared;
    logic [7:0] v;
    // Timer ticks beyond the k waited cycles, both while the stopping control write completes
    localparam int TICK_LAG = 2;

    timer8_waveform_modes DUT (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ovf_serviced(ovf_serviced),
        .cmpa_serviced(cmpa_serviced), .ovf_irq(ovf_irq), .cmpa_irq(cmpa_irq),
        .compare_a_output(compare_a_output), .compare_a_output_oe(compare_a_output_oe));

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    // ------------------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // Expected {output, compare flag, overflow flag, count} after n timer ticks
    function automatic logic [10:0] sim(input logic [2:0] m, input logic [1:0] com,
                                        input logic [7:0] cmp, input logic [7:0] start,
                                        input int n);
        logic [7:0] c;
        logic [7:0] top;
        logic       ov;
        logic       cf;
        logic       q;
        logic       fast;
        logic       ph;
        logic       dn;
        c    = start;
        ov   = 1'b0;
        cf   = 1'b0;
        q    = 1'b0;
        dn   = 1'b0;
        ph   = (m == timer8_pkg::MODE_PC_FF || m == timer8_pkg::MODE_PC_CMP);
        fast = (m == timer8_pkg::MODE_FAST_FF || m == timer8_pkg::MODE_FAST_CM);
        top  = (m == timer8_pkg::MODE_CTC || m == timer8_pkg::MODE_PC_CMP ||
                m == timer8_pkg::MODE_FAST_CM) ? cmp : timer8_pkg::COUNT_MAX;
        for (int i = 0; i < n; i++) begin
            if (c == cmp) begin
                cf = 1'b1;
                if (ph) begin
                    // Output mode 2 clears on the way up and sets on the way down
                    if (com[1]) q = com[0] ^ dn;
                end else if (fast && com[1]) q = com[0];
                else if ((!fast || m[2]) && com != 2'h0) q = (com == 2'h1) ? ~q : com[0];
            end
            if (ph) begin
                if (!dn && c == top) dn = 1'b1;
                else if (dn && c == timer8_pkg::COUNT_BOTTOM) begin
                    dn = 1'b0;
                    ov = 1'b1;
                end
                c = dn ? c - 8'h01 : c + 8'h01;
            end else begin
                if (fast ? c == top : c == timer8_pkg::COUNT_MAX) ov = 1'b1;
                if (fast && c == top && com[1]) q = ~com[0];
                c = (c == top) ? 8'h00 : c + 8'h01;
            end
        end
        return {q, cf, ov, c};
    endfunction : sim

    task automatic reset_dut();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask : reset_dut

    task automatic run_case(input logic [2:0] m, input logic [1:0] com, input logic [7:0] cmp,
                            input logic [7:0] start, input int k, input logic [7:0] en,
                            input logic calib);
        logic [10:0] exp;
        reset_dut();
        wr_reg(timer8_pkg::ADDR_COMPARE, cmp);
        wr_reg(timer8_pkg::ADDR_COUNTER, start);
        wr_reg(timer8_pkg::ADDR_ENABLE, en);
        wr_reg(timer8_pkg::ADDR_CONTROL, {com, 3'h1, m});
        repeat (k) @(posedge core_clk);
        wr_reg(timer8_pkg::ADDR_CONTROL, {com, timer8_pkg::CS_STOPPED, m});
        repeat (3) @(posedge core_clk);
        rd_reg(timer8_pkg::ADDR_COUNTER, v);
        if (calib) chk(v, start + 8'(k + TICK_LAG), "latency");
        exp = sim(m, com, cmp, start, k + TICK_LAG);
        chk(v, exp[7:0], "count");
        rd_reg(timer8_pkg::ADDR_FLAGS, v);
        chk(v, {6'h0, exp[9:8]}, "flags");
        chk({6'h0, cmpa_irq, ovf_irq}, {6'h0, exp[9:8] & en[1:0]}, "irq");
        chk({7'h0, compare_a_output}, {7'h0, exp[10]}, "wave");
        chk({7'h0, compare_a_output_oe}, {7'h0, en[7] & (com != 2'h0)}, "pin");
        @(posedge core_clk);
        // Service and a written one take turns on the two flags
        ovf_serviced  <= !k[0];
        cmpa_serviced <= k[0];
        @(posedge core_clk);
        ovf_serviced  <= 1'b0;
        cmpa_serviced <= 1'b0;
        wr_reg(timer8_pkg::ADDR_FLAGS, k[0] ? 8'h01 : 8'h02);
        rd_reg(timer8_pkg::ADDR_FLAGS, v);
        chk(v, 8'h00, "flag clear");
        $display("Test mode %0d com %0d cmp %h start %h ticks %0d done", m, com, cmp, start, k);
    endtask : run_case

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        rst_n = 1'b0; addr = 3'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        ovf_serviced = 1'b0; cmpa_serviced = 1'b0;
        n_errors = 0; n_compared = 0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        v = 8'($urandom(16));
        // Reset values, unmapped places read as zero
        for (int a = 0; a < 8; a++) begin
            rd_reg(3'(a), v);
            chk(v, 8'h00, "reset value");
        end
        $display("Test reset values done");
        // The first case also checks the tick lag that later windows rely on
        run_case(3'h0, 2'h0, 8'h80, 8'h10, 20, 8'h00, 1'b1);
        run_case(3'h0, 2'h1, 8'hff, 8'hfe, 3, 8'h81, 1'b0);
        run_case(3'h2, 2'h1, 8'h00, 8'h00, 40, 8'h82, 1'b0);
        run_case(3'h2, 2'h3, 8'h20, 8'hc0, 80, 8'h83, 1'b0);
        run_case(3'h2, 2'h2, 8'hff, 8'hf0, 30, 8'h83, 1'b0);
        run_case(3'h3, 2'h2, 8'h40, 8'hf8, 30, 8'h81, 1'b0);
        run_case(3'h3, 2'h3, 8'h40, 8'hf8, 30, 8'h81, 1'b0);
        run_case(3'h4, 2'h1, 8'h05, 8'hfc, 20, 8'h80, 1'b0);
        run_case(3'h6, 2'h1, 8'h05, 8'hfc, 20, 8'h80, 1'b0);
        run_case(3'h1, 2'h2, 8'h80, 8'h70, 300, 8'h81, 1'b0);
        run_case(3'h5, 2'h3, 8'h10, 8'h08, 40, 8'h83, 1'b0);
        run_case(3'h7, 2'h1, 8'h20, 8'h00, 70, 8'h81, 1'b0);
        run_case(3'h7, 2'h2, 8'h20, 8'h00, 70, 8'h81, 1'b0);
        for (int i = 0; i < 30; i++)
            run_case(3'($urandom), 2'($urandom), 8'($urandom_range(254, 0)),
                     8'($urandom), $urandom_range(300, 1), 8'($urandom) & 8'h83, 1'b0);
        // Divide-by-8 tick rate, loose window for prescaler phase
        reset_dut();
        wr_reg(timer8_pkg::ADDR_CONTROL, {2'h0, 3'h2, 3'h0});
        repeat (160) @(posedge core_clk);
        wr_reg(timer8_pkg::ADDR_CONTROL, 8'h00);
        rd_reg(timer8_pkg::ADDR_COUNTER, v);
        chk({7'h0, v >= 8'h12 && v <= 8'h16}, 8'h01, "prescale");
        $display("Test prescaler done");
        end_sim();
    end

    initial begin
        // About 40,000 cycles, well past the longest possible run
        #400_000;
        n_errors++;
        end_sim();
    end
endmodule : test_timer8_waveform_modes
